// ### pmr_core_model.sv
`default_nettype none
module pmr_core_model #(
  parameter int unsigned LOCK_CYC = 40
) (
  // Clock and PLL power
  input  wire logic       core_clk,
  input  wire logic       pllOn,
  // Bench commands
  input  wire logic       sleepCmd,
  input  wire logic       irqCmd,
  input  wire logic [7:0] wakeCmd,
  input  wire logic       dpdWakeCmd,
  // Toward the controller
  output logic            sleepReq,
  output logic            irqPending,
  output logic            gpioWake,
  output logic            wdtIrq,
  output logic            usbIrq,
  output logic            rtcIrq,
  output logic      [3:0] uartIrq,
  output logic            deepPdWakePin_b,
  output logic            pllLocked
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned lockCnt;

  initial
  begin
    {sleepReq, irqPending, gpioWake, wdtIrq, usbIrq, rtcIrq} = '0;
    uartIrq = 4'h0;
    deepPdWakePin_b = 1'b1;
    pllLocked = 1'b0;
    lockCnt = 0;
  end

  // Core requests and wake sources, launched just after the edge
  always @(posedge core_clk)
  begin
    sleepReq <= sleepCmd;
    irqPending <= irqCmd;
    // Serial ports are taken as already set up for wake-up
    {uartIrq, rtcIrq, usbIrq, wdtIrq, gpioWake} <= wakeCmd;
    deepPdWakePin_b <= ~dpdWakeCmd;
  end

  // Lock only after a settling span with the PLL powered
  always @(posedge core_clk)
  begin
    if (!pllOn)
    begin
      lockCnt <= 0;
      pllLocked <= 1'b0;
    end
    else if (lockCnt == LOCK_CYC)
      pllLocked <= 1'b1;
    else
      lockCnt <= lockCnt + 1;
  end
endmodule : pmr_core_model
`default_nettype wire

// ### pmr_pkg.sv
// Function
// - Pin, watchdog, power-on and brownout resets merge into one chip reset.
// - Any chip reset starts the RC oscillator and flash initialisation.
// - After internal reset the core fetches from address 0, defaults loaded.
// - Internal reset state drives the reset status output.
// - Reset pin low 50 ns or more resets and wakes from low power.
// - Reset pin is ignored in deep power-down.
// - Power-up and deep power-down wake select the 12 MHz RC oscillator.
// - After chip reset the PLL is off and bypassed until software enables it.
// - Sleep stops only the core clock; peripherals keep running.
// - Sleep holds execution until reset or interrupt.
// - Deep-sleep keeps only the RC oscillator; analog off, flash standby.
// - Deep-sleep wakes on reset, GPIO, watchdog, USB, RTC, serial port.
// - Power-down stops all clocks but watchdog oscillator; analog, flash off.
// - Power-down wakes on the same sources as deep-sleep.
// - Deep power-down powers off all; wakes on wake pin or RTC.
// - Lock bit refuses deep power-down entry.
// - Brownout below selected level raises interrupt and readable status.
// - Two selectable brownout levels; crossing the selected one forces reset.
// - Writable register holds one clock enable per peripheral.
`default_nettype none
package pmr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PIN_MIN_NS    = 50;
  localparam int unsigned PIN_MIN_CYC   =
    (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_HOLD_CYC  = 8;
  localparam int unsigned NUM_WAKE      = 8;
  localparam int unsigned ADDR_W        = 4;
  localparam logic [31:0] BOOT_ADDR     = 32'h0000_0000;
  localparam logic [3:0]  ADR_CTRL      = 4'h0;
  localparam logic [3:0]  ADR_WAKE      = 4'h4;
  localparam logic [3:0]  ADR_PCLK      = 4'h8;
  localparam logic [3:0]  ADR_STAT      = 4'hC;
  localparam logic [1:0]  SEL_SLEEP     = 2'h0;
  localparam logic [1:0]  SEL_DSLEEP    = 2'h1;
  localparam logic [1:0]  SEL_PDOWN     = 2'h2;
  localparam logic [1:0]  SEL_DPD       = 2'h3;
  localparam logic [1:0]  CLK_IRC       = 2'h0;
  localparam logic [1:0]  CLK_SYSOSC    = 2'h1;
  localparam logic [1:0]  CLK_PLL       = 2'h2;
  localparam logic [7:0]  WAKE_RST      = 8'hFF;
  localparam int unsigned CAUSE_LSB     = 5;
  localparam int unsigned CAUSE_W       = 5;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'h0,
    ST_SLEEP  = 3'h1,
    ST_DSLEEP = 3'h2,
    ST_PDOWN  = 3'h3,
    ST_DPD    = 3'h4
  } pmr_state_e;

  typedef struct packed {
    logic [1:0] clkSel;
    logic       pllOn;
    logic       pllBypass;
    logic       bodRstEn;
    logic       bodRstLvl;
    logic       bodIntLvl;
    logic       bodKeep;
    logic       wdOscKeep;
    logic       wdtOnIrc;
    logic       dpdLock;
    logic [1:0] modeSel;
  } pmr_ctrl_s;

  localparam pmr_ctrl_s CTRL_RST = '{
    clkSel: CLK_IRC, pllOn: 1'b0, pllBypass: 1'b1, bodRstEn: 1'b1,
    bodRstLvl: 1'b0, bodIntLvl: 1'b0, bodKeep: 1'b0, wdOscKeep: 1'b0,
    wdtOnIrc: 1'b0, dpdLock: 1'b0, modeSel: SEL_SLEEP};

  typedef struct packed {
    logic dpdWake;
    logic brownout_detector;
    logic por;
    logic wdt;
    logic pin;
  } pmr_cause_s;

  typedef struct packed {
    pmr_cause_s cause;
    logic       pllLocked;
    logic       bodIrq;
    pmr_state_e mode;
  } pmr_stat_s;

  typedef struct packed {
    logic coreClkEn;
    logic ircOn;
    logic ircOutEn;
    logic sysOscOn;
    logic wdOscOn;
    logic pllOn;
    logic pllBypass;
    logic analogOn;
    logic flashOn;
    logic flashStandby;
    logic bodOn;
    logic corePowerOn;
  } pmr_gate_s;
endpackage : pmr_pkg
`default_nettype wire

// ### pmr_power_reset_ctrl.sv
// The strobed register port and the register addresses were chosen for this implementation.
`default_nettype none
module pmr_power_reset_ctrl #(
  parameter int unsigned NPERIPH = 16
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  // Register port
  input  wire logic [pmr_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [31:0]              regWrData,
  input  wire logic                     regWrStb,
  input  wire logic                     regRdStb,
  output logic      [31:0]              regRdData,
  // Reset sources
  input  wire logic                     resetPin_b,
  input  wire logic                     wdtReset,
  input  wire logic [1:0]               bodBelow,
  // Processor core
  input  wire logic                     sleepReq,
  input  wire logic                     irqPending,
  output logic                          coreRst,
  output logic      [31:0]              fetchAddr,
  // Wake sources
  input  wire logic                     gpioWake,
  input  wire logic                     wdtIrq,
  input  wire logic                     usbIrq,
  input  wire logic                     rtcIrq,
  input  wire logic [3:0]               uartIrq,
  input  wire logic                     deepPdWakePin_b,
  // Clock and power control
  input  wire logic                     pllLocked,
  output pmr_pkg::pmr_gate_s            gate,
  output logic      [NPERIPH-1:0]       periphClkEn,
  output logic      [1:0]               mainClkSel,
  // Status
  output logic                          resetStatusOut,
  output logic                          flashInitStart,
  output logic                          bodIrq
);
  import pmr_pkg::*;

  localparam int unsigned PCNT_W = $clog2(PIN_MIN_CYC + 1);
  localparam int unsigned RCNT_W = $clog2(RST_HOLD_CYC + 1);
  localparam logic [PCNT_W-1:0] PIN_LAST = PCNT_W'(PIN_MIN_CYC - 1);
  localparam logic [RCNT_W-1:0] RST_LOAD = RCNT_W'(RST_HOLD_CYC);

  generate
    if (NPERIPH < 1 || NPERIPH > 32)
    begin : g_bad_nperiph
      $error("NPERIPH must be 1 to 32");
    end
  endgenerate

  // ************************************************************
  // Reset synchroniser
  // ************************************************************
  logic rstMeta;
  logic rstSync_b;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta   <= 1'b0;
      rstSync_b <= 1'b0;
    end
    else
    begin
      rstMeta   <= 1'b1;
      rstSync_b <= rstMeta;
    end
  end

  // ************************************************************
  // Reset sources
  // ************************************************************
  pmr_state_e         state;
  pmr_state_e         next_state;
  pmr_ctrl_s          ctrl;
  logic [PCNT_W-1:0]  pinLowCnt;
  logic [RCNT_W-1:0]  rstCnt;
  logic               pinRst;
  logic               wdtRst;
  logic               bodLive;
  logic               bodRst;
  logic               dpdWake;
  logic               rstReq;
  logic               intRst;

  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      pinLowCnt <= '0;
    else if (resetPin_b || state == ST_DPD)
      pinLowCnt <= '0;
    else if (pinLowCnt != PIN_LAST)
      pinLowCnt <= pinLowCnt + PCNT_W'(1);
  end

  assign pinRst  = !resetPin_b && state != ST_DPD &&
                   pinLowCnt == PIN_LAST;
  assign wdtRst  = wdtReset && state != ST_DPD;
  assign bodLive = state == ST_ACTIVE || state == ST_SLEEP ||
                   ((state == ST_DSLEEP || state == ST_PDOWN) &&
                    ctrl.bodKeep);
  assign bodRst  = bodLive && ctrl.bodRstEn &&
                   bodBelow[ctrl.bodRstLvl];
  assign dpdWake = state == ST_DPD &&
                   (!deepPdWakePin_b || rtcIrq);
  assign rstReq  = pinRst || wdtRst || bodRst || dpdWake;
  assign intRst  = rstCnt != '0;

  // Internal reset stretcher; power-on loads it too
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      rstCnt <= RST_LOAD;
    else if (rstReq)
      rstCnt <= RST_LOAD;
    else if (rstCnt != '0)
      rstCnt <= rstCnt - RCNT_W'(1);
  end

  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      coreRst        <= 1'b1;
      resetStatusOut <= 1'b1;
      flashInitStart <= 1'b1;
      fetchAddr      <= BOOT_ADDR;
    end
    else
    begin
      coreRst        <= intRst;
      resetStatusOut <= intRst;
      flashInitStart <= rstReq && !intRst;
      fetchAddr      <= BOOT_ADDR;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [NUM_WAKE-1:0] wakeEn;
  logic [NUM_WAKE-1:0] wakeSrc;
  logic [NPERIPH-1:0]  pclkEn;
  pmr_cause_s          cause;
  pmr_cause_s          causeClr;
  pmr_stat_s           stat;
  logic                wrCtrl;
  logic                wrStat;

  assign wrCtrl   = regWrStb && !intRst && regAddr == ADR_CTRL;
  assign wrStat   = regWrStb && regAddr == ADR_STAT;
  assign causeClr = wrStat ? pmr_cause_s'(regWrData[CAUSE_LSB +: CAUSE_W])
                           : pmr_cause_s'('0);

  // Chip reset returns every control register to its default
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      ctrl <= CTRL_RST;
    else if (intRst)
      ctrl <= CTRL_RST;
    else if (wrCtrl)
      ctrl <= pmr_ctrl_s'(regWrData[$bits(pmr_ctrl_s)-1:0]);
  end

  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      wakeEn <= WAKE_RST;
    else if (intRst)
      wakeEn <= WAKE_RST;
    else if (regWrStb && regAddr == ADR_WAKE)
      wakeEn <= regWrData[NUM_WAKE-1:0];
  end

  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      pclkEn <= '1;
    else if (intRst)
      pclkEn <= '1;
    else if (regWrStb && regAddr == ADR_PCLK)
      pclkEn <= regWrData[NPERIPH-1:0];
  end

  // Reset cause flags survive chip reset except power-on, which sets only por; a new cause wins over clear
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      cause <= '{dpdWake: 1'b0, brownout_detector: 1'b0, por: 1'b1,
                 wdt: 1'b0, pin: 1'b0};
    else
    begin
      cause.pin     <= pinRst  || (cause.pin     && !causeClr.pin);
      cause.wdt     <= wdtRst  || (cause.wdt     && !causeClr.wdt);
      cause.por     <= cause.por && !causeClr.por;
      cause.brownout_detector     <= bodRst  || (cause.brownout_detector     && !causeClr.brownout_detector);
      cause.dpdWake <= dpdWake ||
                       (cause.dpdWake && !causeClr.dpdWake);
    end
  end

  assign stat = '{cause: cause, pllLocked: pllLocked,
                  bodIrq: bodIrq, mode: state};

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      regRdData <= '0;
    else if (regRdStb)
    begin
      case (regAddr)
        ADR_CTRL: regRdData <= 32'(ctrl);
        ADR_WAKE: regRdData <= 32'(wakeEn);
        ADR_PCLK: regRdData <= 32'(pclkEn);
        ADR_STAT: regRdData <= 32'(stat);
        default:  regRdData <= '0;
      endcase
    end
    else
      regRdData <= '0;
  end

  // ************************************************************
  // Power mode sequencer
  // ************************************************************
  assign wakeSrc = {uartIrq, rtcIrq, usbIrq, wdtIrq, gpioWake};

  always_comb
  begin
    next_state = state;
    case (state)
      ST_ACTIVE:
        if (sleepReq)
        begin
          if (ctrl.modeSel == SEL_SLEEP)
            next_state = ST_SLEEP;
          else if (ctrl.modeSel == SEL_DSLEEP)
            next_state = ST_DSLEEP;
          else if (ctrl.modeSel == SEL_PDOWN)
            next_state = ST_PDOWN;
          else if (!ctrl.dpdLock)
            next_state = ST_DPD;
        end
      ST_SLEEP:
        if (irqPending)
          next_state = ST_ACTIVE;
      ST_DSLEEP, ST_PDOWN:
        if (|(wakeSrc & wakeEn))
          next_state = ST_ACTIVE;
      ST_DPD:
        next_state = ST_DPD;
      default:
        next_state = ST_ACTIVE;
    endcase
  end

  // A chip reset also ends any low-power mode
  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      state <= ST_ACTIVE;
    else if (intRst)
      state <= ST_ACTIVE;
    else
      state <= next_state;
  end

  // ************************************************************
  // Clock and power gating
  // ************************************************************
  pmr_gate_s next_gate;

  always_comb
  begin
    next_gate = '{coreClkEn: 1'b1, ircOn: 1'b1, ircOutEn: 1'b1,
                  sysOscOn: ctrl.clkSel == CLK_SYSOSC,
                  wdOscOn: ctrl.wdOscKeep, pllOn: ctrl.pllOn,
                  pllBypass: ctrl.pllBypass || !ctrl.pllOn,
                  analogOn: 1'b1, flashOn: 1'b1, flashStandby: 1'b0,
                  bodOn: 1'b1, corePowerOn: 1'b1};
    case (state)
      ST_ACTIVE:
        next_gate.coreClkEn = 1'b1;
      ST_SLEEP:
        next_gate.coreClkEn = 1'b0;
      ST_DSLEEP:
      begin
        next_gate.coreClkEn    = 1'b0;
        next_gate.ircOutEn     = ctrl.wdtOnIrc;
        next_gate.sysOscOn     = 1'b0;
        next_gate.pllOn        = 1'b0;
        next_gate.pllBypass    = 1'b1;
        next_gate.analogOn     = 1'b0;
        next_gate.flashStandby = 1'b1;
        next_gate.bodOn        = ctrl.bodKeep;
      end
      ST_PDOWN:
      begin
        next_gate.coreClkEn = 1'b0;
        next_gate.ircOn     = 1'b0;
        next_gate.ircOutEn  = 1'b0;
        next_gate.sysOscOn  = 1'b0;
        next_gate.pllOn     = 1'b0;
        next_gate.pllBypass = 1'b1;
        next_gate.analogOn  = 1'b0;
        next_gate.flashOn   = 1'b0;
        next_gate.bodOn     = ctrl.bodKeep;
      end
      ST_DPD:
        next_gate = '0;
      default:
        next_gate.coreClkEn = 1'b0;
    endcase
    if (intRst)
    begin
      next_gate.coreClkEn   = 1'b0;
      next_gate.ircOn       = 1'b1;
      next_gate.ircOutEn    = 1'b1;
      next_gate.corePowerOn = 1'b1;
      next_gate.flashOn     = 1'b1;
      next_gate.pllOn       = 1'b0;
      next_gate.pllBypass   = 1'b1;
      next_gate.sysOscOn    = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      gate        <= '{coreClkEn: 1'b0, ircOn: 1'b1, ircOutEn: 1'b1,
                       pllBypass: 1'b1, flashOn: 1'b1,
                       corePowerOn: 1'b1, default: 1'b0};
      periphClkEn <= '0;
      mainClkSel  <= CLK_IRC;
      bodIrq      <= 1'b0;
    end
    else
    begin
      gate        <= next_gate;
      periphClkEn <= ((state == ST_ACTIVE || state == ST_SLEEP) &&
                      !intRst) ? pclkEn : '0;
      mainClkSel  <= intRst ? CLK_IRC : ctrl.clkSel;
      bodIrq      <= bodLive && bodBelow[ctrl.bodIntLvl];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync_b);

  a_reset_merge: assert property (
    (wdtRst || bodRst || pinRst) |=> intRst ##1 coreRst)
    else $error("reset source did not reach chip reset");
  a_irc_on_reset: assert property (
    $rose(intRst) |-> flashInitStart ##1 gate.ircOn)
    else $error("reset did not start oscillator and flash init");
  a_status_pin: assert property (
    intRst |=> resetStatusOut && fetchAddr == BOOT_ADDR)
    else $error("reset status output not following reset");
  a_pin_two_low: assert property (
    (!resetPin_b && state != ST_DPD) [*2] |=> intRst)
    else $error("reset pin pulse ignored");
  a_dpd_pin_ignore: assert property (
    (state == ST_DPD && !rtcIrq && deepPdWakePin_b) |=>
    !intRst || $past(intRst))
    else $error("reset pin acted in deep power-down");
  a_pll_bypass: assert property (
    intRst |=> gate.pllBypass && !gate.pllOn &&
               mainClkSel == CLK_IRC)
    else $error("pll not bypassed after reset");
  a_sleep_core: assert property (
    (state == ST_SLEEP && !intRst) |=>
    !gate.coreClkEn && periphClkEn == $past(pclkEn))
    else $error("sleep gating wrong");
  a_sleep_wake: assert property (
    (state == ST_SLEEP && irqPending && !rstReq && !intRst) |=>
    state == ST_ACTIVE ##1 gate.coreClkEn)
    else $error("sleep did not resume on interrupt");
  a_dsleep_gate: assert property (
    (state == ST_DSLEEP && !intRst) |=>
    periphClkEn == '0 && !gate.sysOscOn && gate.flashStandby)
    else $error("deep-sleep gating wrong");
  a_dpd_lock: assert property (
    (state == ST_ACTIVE && sleepReq && ctrl.dpdLock && !intRst)
    |=> state != ST_DPD)
    else $error("deep power-down entered while locked");
  a_bod_irq: assert property (
    (bodLive && bodBelow[ctrl.bodIntLvl]) |=> bodIrq)
    else $error("brownout interrupt missing");
endmodule : pmr_power_reset_ctrl
`default_nettype wire

// ### pmr_tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pmr_pkg::*;
  localparam int unsigned NP = 16;
  logic              core_clk = 1'b0;
  logic              rst_b;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0]       regWrData, regRdData, fetchAddr, v;
  logic              regWrStb, regRdStb, resetPin_b, wdtReset;
  logic [1:0]        bodBelow, mainClkSel;
  logic              sleepReq, irqPending, coreRst, gpioWake, wdtIrq;
  logic              usbIrq, rtcIrq, deepPdWakePin_b, pllLocked;
  logic [3:0]        uartIrq;
  pmr_gate_s         gate;
  logic [NP-1:0]     periphClkEn;
  logic              resetStatusOut, flashInitStart, bodIrq;
  logic              sleepCmd, irqCmd, dpdWakeCmd, rdSeen;
  logic [7:0]        wakeCmd;
  logic [31:0]       expQ[$];
  int                miscompares, testsRun, m, i, n;
  int                seed = 9;

  always #12.5 core_clk = ~core_clk;

  pmr_power_reset_ctrl #(.NPERIPH(NP)) pmr_power_reset_ctrl_inst (
    .core_clk, .rst_b, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .resetPin_b, .wdtReset, .bodBelow, .sleepReq,
    .irqPending, .coreRst, .fetchAddr, .gpioWake, .wdtIrq, .usbIrq,
    .rtcIrq, .uartIrq, .deepPdWakePin_b, .pllLocked, .gate, .periphClkEn,
    .mainClkSel, .resetStatusOut, .flashInitStart, .bodIrq);

  pmr_core_model #(.LOCK_CYC(40)) pmr_core_model_inst (
    .core_clk, .pllOn(gate.pllOn), .sleepCmd, .irqCmd, .wakeCmd,
    .dpdWakeCmd, .sleepReq, .irqPending, .gpioWake, .wdtIrq, .usbIrq,
    .rtcIrq, .uartIrq, .deepPdWakePin_b, .pllLocked);

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    testsRun++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic summarize;
    $display("compares %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Read data stand only in the cycle after the strobe
  always @(negedge core_clk)
  begin
    if (rdSeen)
      check(regRdData, expQ.pop_front());
    rdSeen = regRdStb;
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    summarize();
  end

  // ****************************************
  // Bus and sequence tasks
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrStb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge core_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    repeat (2) @(negedge core_clk);
  endtask : rd

  task automatic slp(input logic [31:0] ctrl);
    wr(ADR_CTRL, ctrl);
    @(posedge core_clk);
    sleepCmd <= 1'b1;
    @(posedge core_clk);
    sleepCmd <= 1'b0;
    repeat (4) @(negedge core_clk);
  endtask : slp

  task automatic pin(input int k);
    @(posedge core_clk);
    resetPin_b <= 1'b0;
    repeat (k) @(posedge core_clk);
    resetPin_b <= 1'b1;
  endtask : pin

  task automatic waitDone;
    n = 0;
    while (coreRst !== 1'b0 && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
    check({coreRst, resetStatusOut}, 2'b00);
    check(fetchAddr, BOOT_ADDR);
    check({mainClkSel, gate.ircOn}, {CLK_IRC, 1'b1});
    check({gate.pllOn, gate.pllBypass}, 2'b01);
    repeat (2) @(negedge core_clk);
  endtask : waitDone

  task automatic waitRst;
    n = 0;
    while (flashInitStart !== 1'b1 && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
    check(flashInitStart, 1'b1);
    n = 0;
    while (coreRst !== 1'b1 && n < 10)
    begin
      @(negedge core_clk);
      n++;
    end
    check({coreRst, resetStatusOut}, 2'b11);
    @(posedge core_clk);
    resetPin_b <= 1'b1;
    wdtReset <= 1'b0;
    bodBelow <= 2'b00;
    dpdWakeCmd <= 1'b0;
    waitDone();
  endtask : waitRst

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {rst_b, regWrStb, regRdStb, wdtReset, rdSeen} = '0;
    {sleepCmd, irqCmd, dpdWakeCmd} = '0;
    {regAddr, regWrData, bodBelow, wakeCmd} = '0;
    resetPin_b = 1'b1;
    repeat (12) @(negedge core_clk);
    check({coreRst, resetStatusOut, flashInitStart}, 3'b111);
    @(posedge core_clk);
    rst_b <= 1'b1;
    waitDone();
    rd(ADR_CTRL, 32'h0000_0300);
    rd(ADR_WAKE, 32'h0000_00FF);
    rd(ADR_PCLK, 32'h0000_FFFF);
    rd(ADR_STAT, 32'h0000_0080);
    rd(4'h2, 32'h0000_0000);
    v = $random(seed);
    wr(ADR_PCLK, {16'h0000, v[15:0]});
    repeat (3) @(negedge core_clk);
    check(periphClkEn, v[15:0]);
    rd(ADR_PCLK, {16'h0000, v[15:0]});
    wr(ADR_STAT, 32'h0000_03E0);
    slp(32'h0000_0300);
    check({gate.coreClkEn, gate.ircOn, gate.flashOn}, 3'b011);
    check(periphClkEn, v[15:0]);
    rd(ADR_STAT, 32'h0000_0001);
    @(posedge core_clk);
    irqCmd <= 1'b1;
    repeat (3) @(posedge core_clk);
    irqCmd <= 1'b0;
    repeat (2) @(negedge core_clk);
    check(gate.coreClkEn, 1'b1);
    rd(ADR_STAT, 32'h0000_0000);
    for (m = 1; m < 3; m++)
      for (i = 0; i < 8; i++)
      begin
        slp(32'h0000_0300 | m);
        if (m == 1 && i == 0)
          check({gate.ircOn, gate.ircOutEn, gate.sysOscOn, gate.pllOn,
                 gate.analogOn, gate.flashStandby}, 6'b100001);
        if (m == 2 && i == 0)
          check({gate.ircOn, gate.wdOscOn, gate.analogOn, gate.flashOn,
                 gate.bodOn}, 5'b00000);
        rd(ADR_STAT, m + 1);
        @(posedge core_clk);
        wakeCmd <= 8'h01 << i;
        repeat (3) @(posedge core_clk);
        wakeCmd <= 8'h00;
        rd(ADR_STAT, 32'h0000_0000);
      end
    wr(ADR_WAKE, 32'h0000_00FE);
    slp(32'h0000_0301);
    @(posedge core_clk);
    wakeCmd <= 8'h01;
    repeat (3) @(posedge core_clk);
    wakeCmd <= 8'h00;
    rd(ADR_STAT, 32'h0000_0002);
    @(posedge core_clk);
    wakeCmd <= 8'h02;
    repeat (3) @(posedge core_clk);
    wakeCmd <= 8'h00;
    rd(ADR_STAT, 32'h0000_0000);
    slp(32'h0000_0307);
    rd(ADR_STAT, 32'h0000_0000);
    check(gate.corePowerOn, 1'b1);
    slp(32'h0000_0303);
    check(gate.corePowerOn, 1'b0);
    pin(2);
    repeat (4) @(negedge core_clk);
    check(gate.corePowerOn, 1'b0);
    @(posedge core_clk);
    dpdWakeCmd <= 1'b1;
    waitRst();
    rd(ADR_STAT, 32'h0000_0200);
    wr(ADR_STAT, 32'h0000_03E0);
    pin(1);
    repeat (4) @(negedge core_clk);
    check(coreRst, 1'b0);
    slp(32'h0000_0300);
    pin(2);
    waitRst();
    rd(ADR_STAT, 32'h0000_0020);
    wr(ADR_STAT, 32'h0000_03E0);
    @(posedge core_clk);
    wdtReset <= 1'b1;
    waitRst();
    rd(ADR_STAT, 32'h0000_0040);
    wr(ADR_STAT, 32'h0000_03E0);
    wr(ADR_CTRL, 32'h0000_0200);
    @(posedge core_clk);
    bodBelow <= 2'b01;
    repeat (3) @(negedge core_clk);
    check({bodIrq, coreRst}, 2'b10);
    rd(ADR_STAT, 32'h0000_0008);
    wr(ADR_CTRL, 32'h0000_0380);
    repeat (4) @(negedge core_clk);
    check(coreRst, 1'b0);
    @(posedge core_clk);
    bodBelow <= 2'b10;
    waitRst();
    rd(ADR_STAT, 32'h0000_0100);
    wr(ADR_CTRL, 32'h0000_0500);
    n = 0;
    // Select the PLL only once it reports lock
    while (pllLocked !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    check({gate.pllOn, gate.pllBypass}, 2'b10);
    rd(ADR_STAT, 32'h0000_0110);
    wr(ADR_CTRL, 32'h0000_1500);
    repeat (3) @(negedge core_clk);
    check(mainClkSel, CLK_PLL);
    pin(2);
    waitRst();
    repeat (3) @(negedge core_clk);
    summarize();
  end
endmodule : tb
`default_nettype wire
